// ==== shared/tpdc_pkg.sv ====
// Constants and types for the touch panel drive control block
package tpdc_pkg;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_TIME_NS = 2500;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;
  localparam int RESULT_W = 12;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;
  localparam logic [RESULT_W-1:0] RESULT_FULL = 12'hfff;
  // Arbitrary base address; bit 0 is replaced by the strap
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h2a;
  localparam logic [2:0] CH_X = 3'h5;
  localparam logic [2:0] CH_Y = 3'h1;
  localparam logic [2:0] CH_PRESS1 = 3'h3;
  localparam logic [2:0] CH_PRESS2 = 3'h4;

  typedef enum logic [4:0] {
    ST_WAIT = 5'b00001,
    ST_SETTLE = 5'b00010,
    ST_SAMPLE = 5'b00100,
    ST_CONV = 5'b01000,
    ST_DONE = 5'b10000
  } tpdc_state_t;

  // Switch order, MSB first: X+ supply, X+ pull-up, X+ to converter, X- return,
  // Y+ supply, Y+ to converter, Y- return, Y- to converter
  typedef logic [7:0] tpdc_sw_t;
  localparam int SWB_X_PLUS_SUPPLY = 7;
  localparam int SWB_X_PLUS_PULLUP = 6;
  localparam int SWB_X_PLUS_ADC = 5;
  localparam int SWB_X_MINUS_RETURN = 4;
  localparam int SWB_Y_PLUS_SUPPLY = 3;
  localparam int SWB_Y_PLUS_ADC = 2;
  localparam int SWB_Y_MINUS_RETURN = 1;
  localparam int SWB_Y_MINUS_ADC = 0;
  localparam tpdc_sw_t SW_OPEN = 8'h00;
  localparam tpdc_sw_t SW_X = 8'h94;
  localparam tpdc_sw_t SW_Y = 8'h2a;
  localparam tpdc_sw_t SW_PRESS1 = 8'h38;
  localparam tpdc_sw_t SW_PRESS2 = 8'h19;
  localparam tpdc_sw_t SW_PEN = 8'h42;
endpackage

// ==== rtl/tpdc_sar.sv ====
// Successive-approximation register for the 12-bit converter
module tpdc_sar
  import tpdc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic cmp_above,
  output logic [RESULT_W-1:0] trial_code,
  output logic [RESULT_W-1:0] result,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [RESULT_W-1:0] code_q, code_d;
  logic [RESULT_W-1:0] bit_q, bit_d;
  logic [RESULT_W-1:0] result_q, result_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  always_comb begin
    code_d = code_q;
    bit_d = bit_q;
    result_d = result_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start) begin
      bit_d = {1'b1, {(RESULT_W-1){1'b0}}};
      code_d = {1'b1, {(RESULT_W-1){1'b0}}};
      busy_d = 1'b1;
    end else if (busy_q) begin
      // Straight binary: a trial bit stays only while the held input is at or above the trial code
      if (!cmp_above) begin
        code_d = code_q & ~bit_q;
      end
      bit_d = bit_q >> 1;
      code_d = code_d | (bit_q >> 1);
      if (bit_q[0]) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        result_d = cmp_above ? code_q : (code_q & ~bit_q);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      code_q <= RESULT_RESET;
      bit_q <= RESULT_RESET;
      result_q <= RESULT_RESET;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      code_q <= code_d;
      bit_q <= bit_d;
      result_q <= result_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign trial_code = code_q;
  assign result = result_q;
  assign done = done_q;
endmodule

// ==== rtl/tpdc_top.sv ====
// Touch panel plate switch sequencing, pen interrupt and conversion control
// Operation
// - Horizontal measurement drives X+ to supply and X- to return, samples Y+, leaves Y- open.
// - Vertical measurement drives Y+ and Y-, samples X+, leaves X- open.
// - Pressure measurement drives Y+ and X-, samples X+ first and Y- second.
// - Pen wait enables the X+ pull-up, opens Y+ and X-, and grounds Y-.
// - With the pen interrupt enabled the interrupt output is low while the touch last sensed in pen wait is set and high otherwise.
// - With the pen interrupt disabled the interrupt output is low whatever the touch.
// - The slave address low bit comes from the address strap and the host must use it.
// - Each result is a 12-bit successive-approximation value of a held sample.
// - Results are straight binary, zero for no input and all ones at full reference.
// - The host picks the measurement through a three-bit channel field that sets the switches.
module tpdc_top
  import tpdc_pkg::*;
(
  // Clock, reset and command side
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire logic [2:0] channel_select_field,
  input wire logic pen_irq_enable,
  output logic cmd_ready,
  // Strap, pen sense and converter
  input wire logic addr_strap_pin,
  output logic [6:0] slave_address,
  input wire logic pen_contact,
  input wire logic cmp_above,
  output logic [RESULT_W-1:0] dac_code,
  output logic sample_hold,
  // Plate switch enables, high closes the switch
  output logic x_plus_terminal_supply,
  output logic x_plus_terminal_pullup,
  output logic x_plus_terminal_adc,
  output logic x_minus_terminal_return,
  output logic y_plus_terminal_supply,
  output logic y_plus_terminal_adc,
  output logic y_minus_terminal_return,
  output logic y_minus_terminal_adc,
  // Interrupt and results
  output logic pen_touch_irq_n,
  output logic [RESULT_W-1:0] result_data,
  output logic [2:0] result_channel,
  output logic result_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  // Sequencer state
  tpdc_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] chan_q, chan_d;
  tpdc_sw_t sw_q, sw_d;

  // Result, pen and strap state
  logic touched_q, touched_d;
  logic irq_n_q, irq_n_d;
  logic strap_q, strap_d;
  logic [RESULT_W-1:0] res_q, res_d;
  logic [2:0] res_ch_q, res_ch_d;
  logic valid_q, valid_d;

  // Converter handshake
  logic sar_start;
  logic sar_done;
  logic [RESULT_W-1:0] sar_result;

  function automatic tpdc_sw_t switch_map(input logic [2:0] ch);
    case (ch)
      CH_X: switch_map = SW_X;
      CH_Y: switch_map = SW_Y;
      CH_PRESS1: switch_map = SW_PRESS1;
      CH_PRESS2: switch_map = SW_PRESS2;
      default: switch_map = SW_OPEN;
    endcase
  endfunction

  function automatic logic channel_known(input logic [2:0] ch);
    case (ch)
      CH_X, CH_Y, CH_PRESS1, CH_PRESS2: channel_known = 1'b1;
      default: channel_known = 1'b0;
    endcase
  endfunction

  tpdc_sar u_sar (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(sar_start),
    .cmp_above(cmp_above),
    .trial_code(dac_code),
    .result(sar_result),
    .done(sar_done)
  );

  // Requests are only looked at in pen wait; while busy cmd_ready is low and anything offered is not taken
  assign cmd_ready = (state_q == ST_WAIT);
  assign sar_start = (state_q == ST_SAMPLE);

  // Sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    chan_d = chan_q;
    sw_d = sw_q;
    case (state_q)
      ST_WAIT: begin
        sw_d = SW_PEN;
        // Unknown channel codes are ignored so the panel never sees an undefined switch set
        if (cmd_valid && channel_known(channel_select_field)) begin
          chan_d = channel_select_field;
          sw_d = switch_map(channel_select_field);
          cnt_d = CNT_W'(SETTLE_CYCLES - 1);
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (cnt_q == '0) begin
          state_d = ST_SAMPLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_SAMPLE: begin
        state_d = ST_CONV;
      end
      ST_CONV: begin
        if (sar_done) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        sw_d = SW_PEN;
        state_d = ST_WAIT;
      end
      default: begin
        sw_d = SW_PEN;
        state_d = ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= ST_WAIT;
      cnt_q <= '0;
      chan_q <= 3'h0;
      sw_q <= SW_PEN;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      chan_q <= chan_d;
      sw_q <= sw_d;
    end
  end

  // Results
  always_comb begin
    res_d = res_q;
    res_ch_d = res_ch_q;
    valid_d = 1'b0;
    if (state_q == ST_DONE) begin
      res_d = sar_result;
      res_ch_d = chan_q;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      res_q <= RESULT_RESET;
      res_ch_q <= 3'h0;
      valid_q <= 1'b0;
    end else begin
      res_q <= res_d;
      res_ch_q <= res_ch_d;
      valid_q <= valid_d;
    end
  end

  // Pen sense and interrupt
  always_comb begin
    touched_d = touched_q;
    // Touch sense is only meaningful with the pull-up on, so hold the last view during measurements
    if (state_q == ST_WAIT) begin
      touched_d = pen_contact;
    end
    irq_n_d = pen_irq_enable ? ~touched_d : 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      touched_q <= 1'b0;
      irq_n_q <= 1'b0;
    end else begin
      touched_q <= touched_d;
      irq_n_q <= irq_n_d;
    end
  end

  // Address strap
  always_comb begin
    strap_d = strap_q;
    if (srst) begin
      strap_d = addr_strap_pin;
    end
  end

  // Strap is caught by the clock while reset is held, not by the reset itself
  always_ff @(posedge sys_clk) begin
    strap_q <= strap_d;
  end

  assign slave_address = {SLAVE_ADDR_BASE[6:1], strap_q};
  assign sample_hold = (state_q == ST_SETTLE) || (state_q == ST_SAMPLE);
  // Switch enables come straight from registers so the plates never see a decode glitch
  assign x_plus_terminal_supply = sw_q[SWB_X_PLUS_SUPPLY];
  assign x_plus_terminal_pullup = sw_q[SWB_X_PLUS_PULLUP];
  assign x_plus_terminal_adc = sw_q[SWB_X_PLUS_ADC];
  assign x_minus_terminal_return = sw_q[SWB_X_MINUS_RETURN];
  assign y_plus_terminal_supply = sw_q[SWB_Y_PLUS_SUPPLY];
  assign y_plus_terminal_adc = sw_q[SWB_Y_PLUS_ADC];
  assign y_minus_terminal_return = sw_q[SWB_Y_MINUS_RETURN];
  assign y_minus_terminal_adc = sw_q[SWB_Y_MINUS_ADC];
  assign pen_touch_irq_n = irq_n_q;
  assign result_data = res_q;
  assign result_channel = res_ch_q;
  assign result_valid = valid_q;
endmodule

// ==== test/tpdc_panel_model.sv ====
// Behavioural panel and comparator on the converter side
module tpdc_panel_model
  import tpdc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sample_hold,
  input wire logic [RESULT_W-1:0] dac_code,
  input wire logic [RESULT_W-1:0] level,
  output logic cmp_above
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [RESULT_W-1:0] held_q = '0;
  // Input tracked only while the hold switch is closed
  always @(posedge sys_clk) begin
    if (sample_hold) begin
      held_q <= level;
    end
  end
  // Ideal comparator, so a straight binary code equals the held level
  assign cmp_above = held_q >= dac_code;
endmodule

// ==== test/tpdc_checker.sv ====
// Port assertions for the touch panel drive control block
module tpdc_checker
  import tpdc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire logic [2:0] channel_select_field,
  input wire logic pen_irq_enable,
  input wire logic cmd_ready,
  input wire logic addr_strap_pin,
  input wire logic [6:0] slave_address,
  input wire logic pen_contact,
  input wire logic x_plus_terminal_supply,
  input wire logic x_plus_terminal_pullup,
  input wire logic x_plus_terminal_adc,
  input wire logic x_minus_terminal_return,
  input wire logic y_plus_terminal_supply,
  input wire logic y_plus_terminal_adc,
  input wire logic y_minus_terminal_return,
  input wire logic y_minus_terminal_adc,
  input wire logic pen_touch_irq_n,
  input wire logic [2:0] result_channel,
  input wire logic result_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire logic [7:0] sw = {x_plus_terminal_supply, x_plus_terminal_pullup, x_plus_terminal_adc,
    x_minus_terminal_return, y_plus_terminal_supply, y_plus_terminal_adc, y_minus_terminal_return,
    y_minus_terminal_adc};
  wire logic take = cmd_valid && cmd_ready;
  wire logic known = channel_select_field inside {CH_X, CH_Y, CH_PRESS1, CH_PRESS2};
  property p_x; take && channel_select_field == CH_X |=> sw == 8'h94; endproperty
  a_x: assert property (p_x) else $error("x switch set wrong");
  property p_y; take && channel_select_field == CH_Y |=> sw == 8'h2a; endproperty
  a_y: assert property (p_y) else $error("y switch set wrong");
  property p_press1; take && channel_select_field == CH_PRESS1 |=> sw == 8'h38; endproperty
  a_press1: assert property (p_press1) else $error("first pressure switch set wrong");
  property p_press2; take && channel_select_field == CH_PRESS2 |=> sw == 8'h19; endproperty
  a_press2: assert property (p_press2) else $error("second pressure switch set wrong");
  property p_wait; cmd_ready [*3] |-> sw == 8'h42; endproperty
  a_wait: assert property (p_wait) else $error("idle switch set wrong");
  property p_on; pen_irq_enable && cmd_ready |=> pen_touch_irq_n == !$past(pen_contact); endproperty
  a_on: assert property (p_on) else $error("irq does not follow touch");
  property p_off; !pen_irq_enable |=> !pen_touch_irq_n; endproperty
  a_off: assert property (p_off) else $error("irq high while disabled");
  property p_strap; $fell(srst) |-> slave_address == {SLAVE_ADDR_BASE[6:1], $past(addr_strap_pin)}; endproperty
  a_strap: assert property (p_strap) else $error("address low bit wrong");
  property p_res; take && known |-> ##41 result_valid && result_channel == $past(channel_select_field, 41); endproperty
  a_res: assert property (p_res) else $error("result late or wrong channel");
  property p_ref; take && !known |=> cmd_ready; endproperty
  a_ref: assert property (p_ref) else $error("bad channel accepted");
  c_res: cover property (take && known ##41 result_valid);
  c_irq: cover property (pen_irq_enable && !pen_touch_irq_n);
  c_ref: cover property (take && !known);
endmodule
bind tpdc_top tpdc_checker u_chk (
  .sys_clk(sys_clk),
  .srst(srst),
  .cmd_valid(cmd_valid),
  .channel_select_field(channel_select_field),
  .pen_irq_enable(pen_irq_enable),
  .cmd_ready(cmd_ready),
  .addr_strap_pin(addr_strap_pin),
  .slave_address(slave_address),
  .pen_contact(pen_contact),
  .x_plus_terminal_supply(x_plus_terminal_supply),
  .x_plus_terminal_pullup(x_plus_terminal_pullup),
  .x_plus_terminal_adc(x_plus_terminal_adc),
  .x_minus_terminal_return(x_minus_terminal_return),
  .y_plus_terminal_supply(y_plus_terminal_supply),
  .y_plus_terminal_adc(y_plus_terminal_adc),
  .y_minus_terminal_return(y_minus_terminal_return),
  .y_minus_terminal_adc(y_minus_terminal_adc),
  .pen_touch_irq_n(pen_touch_irq_n),
  .result_channel(result_channel),
  .result_valid(result_valid)
);

// ==== test/tpdc_top_bench.sv ====
// Self-checking bench for the touch panel drive control block
module tpdc_top_bench
  import tpdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, srst, cmd_valid, pen_irq_enable, addr_strap_pin, pen_contact, cmp_above;
  logic cmd_ready, sample_hold, pen_touch_irq_n, result_valid;
  logic [2:0] channel_select_field, result_channel;
  logic [6:0] slave_address;
  logic [11:0] dac_code, result_data, level;
  logic [2:0] bad[4] = '{3'h0, 3'h2, 3'h6, 3'h7};
  logic [14:0] exp_q[$];
  int mismatches = 0;
  int checked = 0;
  tpdc_top dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .cmd_valid(cmd_valid),
    .channel_select_field(channel_select_field),
    .pen_irq_enable(pen_irq_enable),
    .cmd_ready(cmd_ready),
    .addr_strap_pin(addr_strap_pin),
    .slave_address(slave_address),
    .pen_contact(pen_contact),
    .cmp_above(cmp_above),
    .dac_code(dac_code),
    .sample_hold(sample_hold),
    .x_plus_terminal_supply(),
    .x_plus_terminal_pullup(),
    .x_plus_terminal_adc(),
    .x_minus_terminal_return(),
    .y_plus_terminal_supply(),
    .y_plus_terminal_adc(),
    .y_minus_terminal_return(),
    .y_minus_terminal_adc(),
    .pen_touch_irq_n(pen_touch_irq_n),
    .result_data(result_data),
    .result_channel(result_channel),
    .result_valid(result_valid)
  );
  tpdc_panel_model panel (.sys_clk(sys_clk), .sample_hold(sample_hold), .dac_code(dac_code),
    .level(level), .cmp_above(cmp_above));
  task automatic cmp_result(input logic [14:0] got, input logic [14:0] want);
    checked++;
    if (got !== want) begin
      mismatches++;
      $display("CHECK FAILED %0t result got %h want %h", $time, got, want);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic want);
    checked++;
    if (got !== want) begin
      mismatches++;
      $display("CHECK FAILED %0t flag got %b want %b", $time, got, want);
    end
  endtask
  task automatic cmp_addr(input logic [6:0] got, input logic [6:0] want);
    checked++;
    if (got !== want) begin
      mismatches++;
      $display("CHECK FAILED %0t address got %h want %h", $time, got, want);
    end
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic do_reset(input logic strap);
    srst = 1;
    addr_strap_pin = strap;
    repeat (6) @(negedge sys_clk);
    srst = 0;
    // Strap moves after release to show it is not sampled again
    addr_strap_pin = ~strap;
    @(negedge sys_clk);
    cmp_addr(slave_address, {SLAVE_ADDR_BASE[6:1], strap});
  endtask
  task automatic measure(input logic [2:0] c, input logic [11:0] lvl);
    int n;
    @(negedge sys_clk);
    level = lvl;
    cmd_valid = 1;
    channel_select_field = c;
    pen_contact = 1'($urandom);
    exp_q.push_back({c, lvl});
    @(negedge sys_clk);
    // Held request with another legal code while busy must be ignored
    channel_select_field = (c == CH_X) ? CH_Y : CH_X;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    cmp_flag(cmd_ready, 1'b1);
    cmd_valid = 0;
  endtask
  initial begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (result_valid === 1'b1) begin
      cmp_flag(exp_q.size() > 0, 1'b1);
      if (exp_q.size() > 0) begin
        cmp_result({result_channel, result_data}, exp_q.pop_front());
      end
    end
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    test_done();
  end
  initial begin
    cmd_valid = 0;
    channel_select_field = 3'h0;
    pen_irq_enable = 0;
    pen_contact = 0;
    level = 12'h000;
    void'($urandom(32'h1254288c));
    do_reset(1'b0);
    for (int i = 0; i < 16; i++) begin
      pen_irq_enable = 1'($urandom);
      pen_contact = 1'($urandom);
      @(negedge sys_clk);
      cmp_flag(pen_touch_irq_n, pen_irq_enable & ~pen_contact);
    end
    measure(CH_X, 12'h000);
    measure(CH_Y, 12'hfff);
    measure(CH_PRESS1, 12'($urandom));
    measure(CH_PRESS2, 12'($urandom));
    @(negedge sys_clk);
    cmd_valid = 1;
    foreach (bad[i]) begin
      channel_select_field = bad[i];
      @(negedge sys_clk);
      cmp_flag(cmd_ready, 1'b1);
    end
    cmd_valid = 0;
    do_reset(1'b1);
    measure(CH_X, 12'($urandom));
    repeat (3) @(negedge sys_clk);
    cmp_flag(exp_q.size() == 0, 1'b1);
    test_done();
  end
endmodule
